// *** pwm_ctrl_pkg.sv ***
// Package: timing constants and flag carriers for the off-line PWM core
package pwm_ctrl_pkg;

  localparam int CLK_HZ = 25000000;
  localparam int FREQ_NORMAL_HZ = 65000;
  localparam int FREQ_STANDBY_HZ = 22000;
  localparam int DUTY_MAX_PCT = 70;
  localparam int BLANK_NS = 120;
  localparam int CLK_PERIOD_NS = 40;
  localparam int FILTER_PERIODS = 4;

  // Period counts round down (shortest time), duty cap rounds down
  localparam int PERIOD_NORMAL = CLK_HZ / FREQ_NORMAL_HZ;
  localparam int PERIOD_STANDBY = CLK_HZ / FREQ_STANDBY_HZ;
  localparam int ON_MAX_NORMAL = PERIOD_NORMAL * DUTY_MAX_PCT / 100;
  localparam int ON_MAX_STANDBY = PERIOD_STANDBY * DUTY_MAX_PCT / 100;
  // Blanking is a least time: round up
  localparam int BLANK_CYCLES =
    (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 11;
  localparam int FILT_W = 3;

  typedef struct packed {
    logic regulationTrip;
    logic overcurrentTrip;
    logic peakBelowLight;
    logic peakAboveHeavy;
  } sense_flags_t;

  typedef struct packed {
    logic brownoutLow;
    logic supplyOver;
    logic undervoltageLockout;
    logic thermalAlarm;
  } protect_flags_t;

  typedef enum logic {
    MODE_NORMAL,
    MODE_STANDBY
  } osc_mode_t;

endpackage : pwm_ctrl_pkg

// *** leading_edge_blanking.sv ***
// Leading edge blanking timer for the overcurrent comparator
`timescale 1ns/1ps
module leading_edge_blanking #(
  parameter int BLANK_LEN = pwm_ctrl_pkg::BLANK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic turnOn,
  input wire logic overcurrentRaw,
  output logic overcurrentQualified
);

  logic [7:0] blankCnt_reg;

  // ==========================================================
  // Blanking counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      blankCnt_reg <= 8'h00;
    end else if (ce) begin
      if (turnOn) begin
        blankCnt_reg <= 8'(BLANK_LEN); // [R16]
      end else if (blankCnt_reg != 8'h00) begin
        blankCnt_reg <= blankCnt_reg - 8'h01;
      end
    end
  end

  // Spikes inside the window never reach the latch
  assign overcurrentQualified = overcurrentRaw && (blankCnt_reg == 8'h00)
    && !turnOn; // [R16]

endmodule : leading_edge_blanking

// *** offline_pwm_protection_control.sv ***
// Digital PWM control and protection core of an off-line regulator
`timescale 1ns/1ps
// Functional notes
// R1: Oscillator runs at nominal 65 kHz in normal operation.
// R2: On-time is capped so duty never exceeds about 70 percent.
// R3: Clock pulse sets gate latch; regulation or overcurrent clears; clear wins.
// R4: Whole cycles may be skipped at zero load; operation goes asynchronous.
// R5: Peak current staying below 80 mA switches oscillator to 22 kHz.
// R6: In light load, peak current above 190 mA restores 65 kHz.
// R7: Peak-current indication is digitally filtered before mode changes.
// R8: Brownout below reference inhibits switching; above it resumes.
// R9: Hysteresis current source on while brownout input above reference.
// R10: Brownout shutdown is non-latching and restarts automatically.
// R11: Supply above overvoltage trip stops all switching.
// R12: Overvoltage trip stays latched until undervoltage lockout clears it.
// R13: Overcurrent during on-time ends conduction within the current cycle.
// R14: After overcurrent the switch turns on normally next cycle.
// R15: Overcurrent path clears the gate latch above the current limit.
// R16: Overcurrent comparator ignored for about 120 ns after turn-on.
// R17: Thermal alarm above 150 C stops switching.
// R18: Switching resumes without latching when thermal alarm clears.
// R19: At start-up threshold, internal logic resets before switching enabled.
// R20: Gate drive forced low while undervoltage lockout is active.
// R21: Gate drive low whenever any shutdown condition is active.
module offline_pwm_protection_control #(
  parameter int PERIOD_NORMAL = pwm_ctrl_pkg::PERIOD_NORMAL,
  parameter int PERIOD_STANDBY = pwm_ctrl_pkg::PERIOD_STANDBY,
  parameter int ON_MAX_NORMAL = pwm_ctrl_pkg::ON_MAX_NORMAL,
  parameter int ON_MAX_STANDBY = pwm_ctrl_pkg::ON_MAX_STANDBY,
  parameter int FILTER_PERIODS = pwm_ctrl_pkg::FILTER_PERIODS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire pwm_ctrl_pkg::sense_flags_t sense,
  input wire pwm_ctrl_pkg::protect_flags_t protect,
  output logic gateDrive,
  output logic hysteresisCurrentOn,
  output logic standbyActive,
  output logic overvoltageTripped,
  output logic oscPulse
);

  localparam int W = pwm_ctrl_pkg::CNT_W;
  localparam int FW = pwm_ctrl_pkg::FILT_W;

  logic [W-1:0] periodCnt_reg;
  logic latch_reg;
  logic latchSet;
  logic latchClear;
  logic onCapHit;
  logic ovTrip_reg;
  logic lockoutSeen_reg;
  logic startReset;
  logic shutdown;
  logic ocQualified;
  logic peakHigh_reg;
  logic peakLow_reg;
  logic [FW-1:0] lowCnt_reg;
  logic [FW-1:0] highCnt_reg;
  pwm_ctrl_pkg::osc_mode_t mode_reg;
  logic gate_reg;
  logic hyst_reg;

  function automatic logic [W-1:0] periodOf(pwm_ctrl_pkg::osc_mode_t m);
    periodOf = (m == pwm_ctrl_pkg::MODE_STANDBY) ? W'(PERIOD_STANDBY)
                                                  : W'(PERIOD_NORMAL);
  endfunction : periodOf

  function automatic logic [W-1:0] onMaxOf(pwm_ctrl_pkg::osc_mode_t m);
    onMaxOf = (m == pwm_ctrl_pkg::MODE_STANDBY) ? W'(ON_MAX_STANDBY)
                                                 : W'(ON_MAX_NORMAL);
  endfunction : onMaxOf

  // ==========================================================
  // Start-up and shutdown qualification
  // Lockout release resets oscillator, peak filter and mode state before the first pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lockoutSeen_reg <= 1'b1;
    end else if (ce) begin
      lockoutSeen_reg <= protect.undervoltageLockout;
    end
  end

  assign startReset = !rst_n || protect.undervoltageLockout
    || lockoutSeen_reg; // [R19]

  // Latched overvoltage; only lockout clears it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovTrip_reg <= 1'b0;
    end else if (ce) begin
      if (protect.undervoltageLockout) begin
        ovTrip_reg <= 1'b0; // [R12]
      end else if (protect.supplyOver) begin
        ovTrip_reg <= 1'b1; // [R11]
      end
    end
  end

  // Brownout and thermal are live levels, so recovery is automatic
  assign shutdown = startReset || protect.brownoutLow // [R8] [R10]
    || ovTrip_reg || protect.supplyOver // [R11]
    || protect.thermalAlarm; // [R17] [R18] [R21]

  // ==========================================================
  // Oscillator
  always_ff @(posedge clk) begin
    if (startReset) begin
      periodCnt_reg <= '0;
    end else if (ce) begin
      if (periodCnt_reg >= periodOf(mode_reg) - W'(1)) begin
        periodCnt_reg <= '0; // [R1]
      end else begin
        periodCnt_reg <= periodCnt_reg + W'(1);
      end
    end
  end

  assign oscPulse = (periodCnt_reg == '0) && !startReset;

  // ==========================================================
  // Gate latch, reset dominant
  assign onCapHit = periodCnt_reg >= onMaxOf(mode_reg); // [R2]
  // A regulation trip already present at the clock skips the cycle
  assign latchSet = oscPulse; // [R4] [R14]
  assign latchClear = sense.regulationTrip || ocQualified // [R3] [R15]
    || onCapHit || shutdown; // [R20] [R21]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_reg <= 1'b0;
    end else if (ce) begin
      if (latchClear) begin
        latch_reg <= 1'b0; // [R3] [R13]
      end else if (latchSet) begin
        latch_reg <= 1'b1; // [R3]
      end
    end
  end

  // Overcurrent ends conduction in the same cycle, not a register later
  assign gateDrive = latch_reg && !ocQualified && !shutdown
    && !onCapHit; // [R13] [R20] [R21]

  leading_edge_blanking #(
    .BLANK_LEN(pwm_ctrl_pkg::BLANK_CYCLES)
  ) u_blank (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .turnOn(latchSet && !latchClear),
    .overcurrentRaw(sense.overcurrentTrip),
    .overcurrentQualified(ocQualified)
  );

  // ==========================================================
  // Standby detection with per-period filtering
  // Peak flags are accumulated over a whole period, judged at its end
  always_ff @(posedge clk) begin
    if (startReset) begin
      peakHigh_reg <= 1'b0;
      peakLow_reg <= 1'b0;
    end else if (ce) begin
      if (oscPulse) begin
        peakHigh_reg <= sense.peakAboveHeavy;
        peakLow_reg <= sense.peakBelowLight;
      end else begin
        peakHigh_reg <= peakHigh_reg | sense.peakAboveHeavy;
        peakLow_reg <= peakLow_reg & sense.peakBelowLight;
      end
    end
  end

  // Consecutive agreeing periods needed; a single noisy period resets it
  always_ff @(posedge clk) begin
    if (startReset) begin
      lowCnt_reg <= '0;
      highCnt_reg <= '0;
    end else if (ce && oscPulse) begin
      lowCnt_reg <= peakLow_reg ? lowCnt_reg + FW'(1) : '0; // [R7]
      highCnt_reg <= peakHigh_reg ? highCnt_reg + FW'(1) : '0; // [R7]
      if (lowCnt_reg == FW'(FILTER_PERIODS - 1)) begin
        lowCnt_reg <= '0;
      end
      if (highCnt_reg == FW'(FILTER_PERIODS - 1)) begin
        highCnt_reg <= '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (startReset) begin
      mode_reg <= pwm_ctrl_pkg::MODE_NORMAL;
    end else if (ce && oscPulse) begin
      case (mode_reg)
        pwm_ctrl_pkg::MODE_NORMAL: begin
          if (peakLow_reg && lowCnt_reg == FW'(FILTER_PERIODS - 1)) begin
            mode_reg <= pwm_ctrl_pkg::MODE_STANDBY; // [R5]
          end
        end
        pwm_ctrl_pkg::MODE_STANDBY: begin
          if (peakHigh_reg && highCnt_reg == FW'(FILTER_PERIODS - 1)) begin
            mode_reg <= pwm_ctrl_pkg::MODE_NORMAL; // [R6]
          end
        end
        default: begin
          mode_reg <= pwm_ctrl_pkg::MODE_NORMAL;
        end
      endcase
    end
  end

  assign standbyActive = (mode_reg == pwm_ctrl_pkg::MODE_STANDBY);
  assign overvoltageTripped = ovTrip_reg;

  // ==========================================================
  // Brownout hysteresis current switch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hyst_reg <= 1'b0;
    end else if (ce) begin
      hyst_reg <= !protect.brownoutLow; // [R9]
    end
  end

  assign hysteresisCurrentOn = hyst_reg;

  // Helper copy of gate for edge checks
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gate_reg <= 1'b0;
    end else if (ce) begin
      gate_reg <= gateDrive;
    end
  end

  // ==========================================================
  // Checks
  chk_gate_shutdown: assert property ( // [R21]
    @(posedge clk) disable iff (!rst_n) shutdown |-> !gateDrive)
    else $error("gate high during shutdown");

  chk_lockout_gate: assert property ( // [R20]
    @(posedge clk) disable iff (!rst_n)
    protect.undervoltageLockout |-> !gateDrive)
    else $error("gate high under lockout");

  chk_ov_hold: assert property ( // [R12]
    @(posedge clk) disable iff (!rst_n)
    (ce && protect.supplyOver && !protect.undervoltageLockout)
    ##1 !protect.undervoltageLockout |-> ovTrip_reg)
    else $error("overvoltage trip not held");

  chk_oc_cut: assert property ( // [R13]
    @(posedge clk) disable iff (!rst_n) ocQualified |-> !gateDrive)
    else $error("gate high on overcurrent");

  chk_blank_window: assert property ( // [R16]
    @(posedge clk) disable iff (!rst_n)
    ce && !gate_reg && gateDrive |=> !ocQualified)
    else $error("overcurrent seen inside blanking");

  chk_duty_cap: assert property ( // [R2]
    @(posedge clk) disable iff (!rst_n)
    periodCnt_reg >= onMaxOf(mode_reg) |-> !gateDrive)
    else $error("duty cap exceeded");

  chk_clear_wins: assert property ( // [R3]
    @(posedge clk) disable iff (!rst_n) ce && latchClear |=> !latch_reg)
    else $error("latch set against clear");

  chk_hyst_follow: assert property ( // [R9]
    @(posedge clk) disable iff (!rst_n)
    ce && !protect.brownoutLow |=> hysteresisCurrentOn)
    else $error("hysteresis current not on");

  chk_count_range: assert property ( // [R1]
    @(posedge clk) disable iff (!rst_n)
    periodCnt_reg < periodOf(mode_reg))
    else $error("period counter out of range");

  chk_period_wrap: assert property ( // [R1]
    @(posedge clk) disable iff (!rst_n)
    ce && periodCnt_reg == periodOf(mode_reg) - W'(1)
    |=> periodCnt_reg == '0)
    else $error("period did not wrap");

  chk_cap_clear: assert property ( // [R2]
    @(posedge clk) disable iff (!rst_n) ce && onCapHit |=> !latch_reg)
    else $error("latch kept past duty cap");

  chk_pulse_set: assert property ( // [R3]
    @(posedge clk) disable iff (!rst_n)
    ce && oscPulse && !latchClear |=> latch_reg)
    else $error("latch not set by clock pulse");

  chk_set_source: assert property ( // [R3]
    @(posedge clk) disable iff (!rst_n) $rose(latch_reg) |-> $past(oscPulse))
    else $error("latch set without clock pulse");

  chk_reg_reset: assert property ( // [R3]
    @(posedge clk) disable iff (!rst_n)
    ce && sense.regulationTrip |=> !latch_reg)
    else $error("latch kept against regulation trip");

  chk_skip_cycle: assert property ( // [R4]
    @(posedge clk) disable iff (!rst_n)
    ce && oscPulse && sense.regulationTrip |=> !gateDrive)
    else $error("cycle not skipped");

  chk_standby_entry: assert property ( // [R5]
    @(posedge clk) disable iff (!rst_n)
    $rose(standbyActive) |-> $past(peakLow_reg))
    else $error("standby entered without light load");

  chk_normal_return: assert property ( // [R6]
    @(posedge clk) disable iff (!rst_n)
    $fell(standbyActive) |-> $past(peakHigh_reg) || $past(startReset))
    else $error("standby left without heavy load");

  chk_mode_hold: assert property ( // [R7]
    @(posedge clk) disable iff (!rst_n)
    ce && !oscPulse && !startReset |=> $stable(mode_reg))
    else $error("mode changed inside a period");

  chk_brownout_gate: assert property ( // [R8]
    @(posedge clk) disable iff (!rst_n)
    protect.brownoutLow |-> !gateDrive)
    else $error("gate high during brownout");

  chk_hyst_off: assert property ( // [R9]
    @(posedge clk) disable iff (!rst_n)
    ce && protect.brownoutLow |=> !hysteresisCurrentOn)
    else $error("hysteresis current not off");

  chk_ov_set: assert property ( // [R11]
    @(posedge clk) disable iff (!rst_n)
    ce && protect.supplyOver && !protect.undervoltageLockout
    |=> overvoltageTripped)
    else $error("overvoltage trip not set");

  chk_ov_clear: assert property ( // [R12]
    @(posedge clk) disable iff (!rst_n)
    ce && protect.undervoltageLockout |=> !overvoltageTripped)
    else $error("overvoltage trip not cleared");

  chk_oc_reset: assert property ( // [R15]
    @(posedge clk) disable iff (!rst_n) ce && ocQualified |=> !latch_reg)
    else $error("latch kept against overcurrent");

  // Three cycles is the blanking count at 40 ns
  chk_blank_span: assert property ( // [R16]
    @(posedge clk) disable iff (!rst_n)
    ce && latchSet && !latchClear |=> !ocQualified [*3])
    else $error("blanking window too short");

  chk_thermal_gate: assert property ( // [R17]
    @(posedge clk) disable iff (!rst_n)
    protect.thermalAlarm |-> !gateDrive)
    else $error("gate high during thermal alarm");

  chk_startup_hold: assert property ( // [R19]
    @(posedge clk) disable iff (!rst_n)
    ce && $past(ce) && $fell(protect.undervoltageLockout)
    |-> !oscPulse ##1 periodCnt_reg == '0)
    else $error("start-up reset skipped");

endmodule : offline_pwm_protection_control

// *** pwm_partner_model.sv ***
// Switch-current and comparator model facing the PWM core
`timescale 1ns/1ps
module pwm_partner_model (
  input wire logic clk,
  input wire logic gateDrive,
  input wire logic oscPulse,
  input wire logic ocMode,
  input wire logic [7:0] regAt,
  input wire logic skipAll,
  input wire logic lightLoad,
  input wire logic heavyLoad,
  output pwm_ctrl_pkg::sense_flags_t sense
);
  // ==========================================
  // Ramp and comparators
  // ==========================================
  logic [7:0] onCnt;
  logic ocReg;
  logic regHit;
  // Overcurrent is registered so the spike cannot loop through the gate
  always_ff @(posedge clk) begin
    onCnt <= oscPulse ? 8'h00 : onCnt + {7'h00, gateDrive};
    ocReg <= ocMode & gateDrive;
  end
  // Held trip models zero load, where even a minimum pulse is too long
  assign regHit = skipAll |
    (regAt != 8'h00 && onCnt >= regAt && !oscPulse);
  assign sense = '{regHit, ocReg, lightLoad, heavyLoad};
endmodule : pwm_partner_model

// *** test_offline_pwm_protection_control.sv ***
// Self-checking testbench of the off-line PWM control core
`timescale 1ns/1ps
module test_offline_pwm_protection_control;
  // ==========================================
  // Signals
  // ==========================================
  localparam int PN = 40;
  localparam int PS = 100;
  localparam int MN = 28;
  localparam int MS = 70;
  localparam int BL = pwm_ctrl_pkg::BLANK_CYCLES;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic ocMode = 1'b0;
  logic skipAll = 1'b0;
  logic lightLoad = 1'b0;
  logic heavyLoad = 1'b0;
  logic [7:0] regAt = 8'h00;
  pwm_ctrl_pkg::protect_flags_t protect = 4'h0;
  pwm_ctrl_pkg::sense_flags_t sense;
  logic gateDrive, hysteresisCurrentOn, standbyActive;
  logic overvoltageTripped, oscPulse;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  int per, hiCnt, n;
  // Short periods keep the run brief; caps stay at 70 percent
  offline_pwm_protection_control #(.PERIOD_NORMAL(PN),
    .PERIOD_STANDBY(PS), .ON_MAX_NORMAL(MN), .ON_MAX_STANDBY(MS),
    .FILTER_PERIODS(2)) DUT (.clk(clk), .rst_n(rst_n), .ce(ce),
    .sense(sense), .protect(protect), .gateDrive(gateDrive),
    .hysteresisCurrentOn(hysteresisCurrentOn),
    .standbyActive(standbyActive),
    .overvoltageTripped(overvoltageTripped), .oscPulse(oscPulse));
  pwm_partner_model partner (.clk(clk), .gateDrive(gateDrive),
    .oscPulse(oscPulse), .ocMode(ocMode), .regAt(regAt),
    .skipAll(skipAll), .lightLoad(lightLoad), .heavyLoad(heavyLoad),
    .sense(sense));
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      close_out();
    end
  end
  // ==========================================
  // Helpers
  // ==========================================
  task automatic close_out;
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, lo, up);
    samples_checked++;
    if ((got >= lo && got <= up) !== 1'b1) begin
      err_total++;
      $display("MISMATCH t=%0t got=%0h exp=%0h..%0h", $time, got, lo, up);
    end
  endtask : chk
  // One full period from an oscillator pulse to the next
  task automatic measure(output int p, output int h);
    int w;
    w = 0;
    // Settle past the launching edge before looking at the pulse
    @(negedge clk);
    while (oscPulse !== 1'b1 && w < 2000) begin
      @(negedge clk);
      w++;
    end
    p = 0;
    h = 0;
    do begin
      @(negedge clk);
      p++;
      h += (gateDrive === 1'b1);
    end while (oscPulse !== 1'b1 && p < 2000);
  endtask : measure
  task automatic gl(input int c, output int h);
    h = 0;
    repeat (c) begin
      @(negedge clk);
      h += (gateDrive === 1'b1);
    end
  endtask : gl
  task automatic wait_sb(input logic want, input int lim);
    int w;
    w = 0;
    while (standbyActive !== want && w < lim) begin
      @(negedge clk);
      w++;
    end
  endtask : wait_sb
  // ==========================================
  // Scenarios
  // ==========================================
  task automatic t_normal;
    measure(per, hiCnt);
    chk(per, PN, PN);
    chk(hiCnt, MN - 1, MN);
    chk(hysteresisCurrentOn, 1, 1);
  endtask : t_normal
  // A low clock enable freezes the oscillator and the latch mid-pulse
  task automatic t_ce;
    measure(per, hiCnt);
    @(posedge clk) ce <= 1'b0;
    gl(PN, n);
    chk(n, PN, PN);
    chk(oscPulse, 0, 0);
    @(posedge clk) ce <= 1'b1;
    measure(per, hiCnt);
    chk(per, PN, PN);
    chk(hiCnt, MN - 1, MN);
  endtask : t_ce
  task automatic t_oc;
    @(posedge clk) ocMode <= 1'b1;
    measure(per, hiCnt);
    chk(hiCnt, BL, BL + 1);
    @(posedge clk) ocMode <= 1'b0;
    measure(per, hiCnt);
    chk(hiCnt, MN - 1, MN);
  endtask : t_oc
  task automatic t_reg;
    @(posedge clk) regAt <= 8'h0A;
    measure(per, hiCnt);
    chk(hiCnt, 10, 12);
    @(posedge clk) skipAll <= 1'b1;
    measure(per, hiCnt);
    chk(hiCnt, 0, 0);
    @(posedge clk) skipAll <= 1'b0;
    regAt <= 8'h00;
  endtask : t_reg
  task automatic t_standby;
    // Half a period of light load must not flip the mode
    @(posedge clk) lightLoad <= 1'b1;
    repeat (PN / 2) @(posedge clk);
    lightLoad <= 1'b0;
    measure(per, hiCnt);
    measure(per, hiCnt);
    chk(standbyActive, 0, 0);
    @(posedge clk) lightLoad <= 1'b1;
    wait_sb(1'b1, 6 * PN);
    chk(standbyActive, 1, 1);
    measure(per, hiCnt);
    measure(per, hiCnt);
    chk(per, PS, PS);
    chk(hiCnt, MS - 1, MS);
    @(posedge clk) lightLoad <= 1'b0;
    heavyLoad <= 1'b1;
    wait_sb(1'b0, 6 * PS);
    chk(standbyActive, 0, 0);
    measure(per, hiCnt);
    measure(per, hiCnt);
    chk(per, PN, PN);
    @(posedge clk) heavyLoad <= 1'b0;
  endtask : t_standby
  task automatic t_shut(input int b);
    @(posedge clk) protect[b] <= 1'b1;
    repeat (2) @(posedge clk);
    gl(2 * PN, n);
    chk(n, 0, 0);
    chk(hysteresisCurrentOn, b != 3, b != 3);
    @(posedge clk) protect[b] <= 1'b0;
    measure(per, hiCnt);
    chk(hiCnt, MN - 1, MN);
    chk(hysteresisCurrentOn, 1, 1);
  endtask : t_shut
  task automatic t_ovp;
    @(posedge clk) protect.supplyOver <= 1'b1;
    repeat (2) @(posedge clk);
    protect.supplyOver <= 1'b0;
    gl(2 * PN, n);
    chk(n, 0, 0);
    chk(overvoltageTripped, 1, 1);
    @(posedge clk) protect.undervoltageLockout <= 1'b1;
    gl(PN, n);
    chk(n, 0, 0);
    @(posedge clk) protect.undervoltageLockout <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (oscPulse !== 1'b1 && n < 50);
    chk(n, 1, 6);
    chk(overvoltageTripped, 0, 0);
    measure(per, hiCnt);
    chk(hiCnt, MN - 1, MN);
  endtask : t_ovp
  // ==========================================
  // Main sequence
  // ==========================================
  initial begin
    repeat (5) @(posedge clk);
    chk(gateDrive, 0, 0);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_normal();
    t_ce();
    t_oc();
    t_reg();
    t_standby();
    t_shut(3);
    t_shut(0);
    t_ovp();
    close_out();
  end
endmodule : test_offline_pwm_protection_control
